// ### rtl/interrupt_flag_and_wake_logic.sv
// interrupt flags, enables, priority and wake control
// assumes core handshakes and event pulses share clock_i
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module interrupt_flag_and_wake_logic
  import irq_wake_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [irq_wake_pkg::ADDR_W-1:0] addr_i,
  input wire logic [irq_wake_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [irq_wake_pkg::DATA_W-1:0] rdata_o,
  input wire logic [irq_wake_pkg::PIN_N-1:0] pins_i,
  input wire logic timer_tick_i,
  input wire logic [2:0] gate_event_i,
  input wire logic core_sleep_i,
  input wire logic step_done_i,
  input wire logic vec_ack_i,
  input wire logic [irq_wake_pkg::PC_W-1:0] pc_i,
  input wire logic [7:0] working_register_i,
  input wire logic [7:0] status_i,
  input wire logic [7:0] bsr_i,
  output logic irq_o,
  output logic wake_o,
  output logic vec_req_o,
  output logic vec_hi_o,
  output logic [irq_wake_pkg::PC_W-1:0] ret_pc_o,
  output logic [7:0] shadow_working_register_o,
  output logic [7:0] shadow_status_o,
  output logic [7:0] shadow_bsr_o
);
  import irq_wake_pkg::*;

  function automatic logic [7:0] w1c(input logic [7:0] q,
      input logic [7:0] set, input logic hit, input logic [7:0] d);
    w1c = (q & ~(hit ? d : 8'h00)) | set;
  endfunction : w1c

  pin_edge_if edges ();
  pin_edge_detect u_edges (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .pins_i(pins_i),
    .edges(edges)
  );

  // ----------------------------------------
  // register port decode
  // ----------------------------------------
  logic [7:0] ctrl_q, flag_q, en_q, prio_q, gflag_q, gen_q, tctrl_q;
  logic [15:0] rise_sel_q, fall_sel_q, pflag_q, cnt_q;
  logic [3:0] sel_q [3];
  logic [7:0] rdata_q;
  wire wr_ctrl = wr_i && addr_i == OFS_CTRL0;
  wire wr_flag = wr_i && addr_i == OFS_FLAG0;
  wire wr_en = wr_i && addr_i == OFS_EN0;
  wire wr_prio = wr_i && addr_i == OFS_PRIO0;
  wire wr_gflag = wr_i && addr_i == OFS_GFLAG;
  wire wr_gen = wr_i && addr_i == OFS_GEN;
  wire wr_tctrl = wr_i && addr_i == OFS_TCTRL;
  wire wr_pfl = wr_i && addr_i == OFS_PFLAG_L;
  wire wr_pfh = wr_i && addr_i == OFS_PFLAG_H;
  wire [15:0] pf_clr = {wr_pfh ? wdata_i : 8'h00, wr_pfl ? wdata_i : 8'h00};
  wire global_enable_bit = ctrl_q[BIT_GIE];
  wire [2:0] edge_sel = ctrl_q[2:0];

  // ----------------------------------------
  // external requests
  // ----------------------------------------
  logic [2:0] ext_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ext
      assign ext_hit[gi] = edge_sel[gi] ? edges.rise[sel_q[gi]]
                                        : edges.fall[sel_q[gi]];
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sel_q[gi] <= RST_SEL;
        end else if (wr_i && addr_i == OFS_SEL_A + 5'(gi)) begin
          sel_q[gi] <= wdata_i[3:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // timer0 counter and rollover
  // ----------------------------------------
  wire t16 = tctrl_q[BIT_T16];
  wire tstep = timer_tick_i && tctrl_q[BIT_TON];
  wire roll8 = tstep && !t16 && cnt_q[7:0] == CNT8_TOP;
  wire roll16 = tstep && t16 && cnt_q == CNT16_TOP;
  wire [15:0] cnt_inc = cnt_q + 16'h0001;
  wire [15:0] cnt_d = t16 ? cnt_inc : {8'h00, cnt_inc[7:0]};

  // ----------------------------------------
  // pin change flags
  // ----------------------------------------
  wire [15:0] pc_hit = (edges.rise & rise_sel_q)
                     | (edges.fall & fall_sel_q);
  wire [15:0] pflag_d = (pflag_q & ~pf_clr) | pc_hit;
  wire pchg_sum = |pflag_q;

  // ----------------------------------------
  // flag register 0 and gate flags
  // ----------------------------------------
  wire [7:0] f0_set = {2'b00, roll8 | roll16, 2'b00, ext_hit};
  wire [7:0] f0_raw = w1c(flag_q, f0_set, wr_flag, wdata_i);
  wire [7:0] f0_d = {f0_raw[7:5], 1'b0, f0_raw[3:0]};
  wire [7:0] gf_set = {5'b00000, gate_event_i};
  wire [7:0] gf_d = w1c(gflag_q, gf_set, wr_gflag, wdata_i) & 8'h07;
  wire [7:0] f0_view = flag_q | (8'(pchg_sum) << BIT_PCHG);

  // ----------------------------------------
  // pending, priority, wake
  // ----------------------------------------
  logic [2:0] snap_en_q;
  wake_state_t st_q, st_d;
  wire [7:0] pend0 = f0_view & en_q;
  wire [7:0] pendg = gflag_q & gen_q;
  wire any_pend = |pend0 || |pendg;
  wire hi_pend = |(pend0 & prio_q);
  wire [7:0] wake0 = {pend0[7:3], pend0[2:0] & snap_en_q};
  wire wake_src = |wake0 || |pendg;
  wire vec_d = global_enable_bit && any_pend && st_q == ST_RUN && !vec_ack_i;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_RUN: if (core_sleep_i) st_d = ST_SLEEP;
      ST_SLEEP: if (wake_src) st_d = ST_STEP;
      ST_STEP: if (step_done_i) st_d = ST_RUN;
      default: st_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= ST_RUN;
      snap_en_q <= 3'b000;
    end else begin
      st_q <= st_d;
      if (st_q == ST_RUN && core_sleep_i) snap_en_q <= en_q[2:0];
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= RST_BYTE;
      en_q <= RST_BYTE;
      prio_q <= RST_BYTE;
      gen_q <= RST_BYTE;
      tctrl_q <= RST_BYTE;
    end else begin
      if (wr_ctrl) ctrl_q <= wdata_i;
      if (wr_en) en_q <= wdata_i;
      if (wr_prio) prio_q <= wdata_i;
      if (wr_gen) gen_q <= wdata_i & 8'h07;
      if (wr_tctrl) tctrl_q <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rise_sel_q <= RST_CNT;
      fall_sel_q <= RST_CNT;
    end else begin
      if (wr_i && addr_i == OFS_RISE_L) rise_sel_q[7:0] <= wdata_i;
      if (wr_i && addr_i == OFS_RISE_H) rise_sel_q[15:8] <= wdata_i;
      if (wr_i && addr_i == OFS_FALL_L) fall_sel_q[7:0] <= wdata_i;
      if (wr_i && addr_i == OFS_FALL_H) fall_sel_q[15:8] <= wdata_i;
    end
  end

  // ----------------------------------------
  // flags and counter; set beats clear
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_q <= RST_BYTE;
      gflag_q <= RST_BYTE;
      pflag_q <= RST_CNT;
      cnt_q <= RST_CNT;
    end else begin
      flag_q <= f0_d;
      gflag_q <= gf_d;
      pflag_q <= pflag_d;
      if (tstep) cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // read mux; unmapped reads zero
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    unique case (addr_i)
      OFS_CTRL0: rd_mux = ctrl_q;
      OFS_FLAG0: rd_mux = f0_view;
      OFS_EN0: rd_mux = en_q;
      OFS_PRIO0: rd_mux = prio_q;
      OFS_GFLAG: rd_mux = gflag_q;
      OFS_GEN: rd_mux = gen_q;
      OFS_RISE_L: rd_mux = rise_sel_q[7:0];
      OFS_RISE_H: rd_mux = rise_sel_q[15:8];
      OFS_FALL_L: rd_mux = fall_sel_q[7:0];
      OFS_FALL_H: rd_mux = fall_sel_q[15:8];
      OFS_PFLAG_L: rd_mux = pflag_q[7:0];
      OFS_PFLAG_H: rd_mux = pflag_q[15:8];
      OFS_SEL_A: rd_mux = {4'h0, sel_q[0]};
      OFS_SEL_B: rd_mux = {4'h0, sel_q[1]};
      OFS_SEL_C: rd_mux = {4'h0, sel_q[2]};
      OFS_TCTRL: rd_mux = tctrl_q;
      OFS_TCNT_L: rd_mux = cnt_q[7:0];
      OFS_TCNT_H: rd_mux = cnt_q[15:8];
      default: rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // outputs, all registered
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= RST_BYTE;
      irq_o <= 1'b0;
      wake_o <= 1'b0;
      vec_req_o <= 1'b0;
      vec_hi_o <= 1'b0;
    end else begin
      rdata_q <= rd_i ? rd_mux : 8'h00;
      irq_o <= any_pend;
      wake_o <= st_q == ST_SLEEP && wake_src;
      vec_req_o <= vec_d;
      vec_hi_o <= vec_d && hi_pend;
    end
  end
  assign rdata_o = rdata_q;

  // context is captured when the core takes the vector
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ret_pc_o <= '0;
      shadow_working_register_o <= RST_BYTE;
      shadow_status_o <= RST_BYTE;
      shadow_bsr_o <= RST_BYTE;
    end else if (vec_ack_i) begin
      ret_pc_o <= pc_i;
      shadow_working_register_o <= working_register_i;
      shadow_status_o <= status_i;
      shadow_bsr_o <= bsr_i;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_ext_set;
    @(posedge clock_i) disable iff (!rstn_i)
    ext_hit[0] |=> flag_q[0];
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("ext flag lost");

  property p_roll8;
    @(posedge clock_i) disable iff (!rstn_i)
    roll8 |=> flag_q[BIT_FIRST_TIMER_COUNT] && cnt_q[7:0] == 8'h00;
  endproperty
  a_roll8: assert property (p_roll8) else $error("8-bit roll");

  property p_roll16;
    @(posedge clock_i) disable iff (!rstn_i)
    roll16 |=> flag_q[BIT_FIRST_TIMER_COUNT] && cnt_q == 16'h0000;
  endproperty
  a_roll16: assert property (p_roll16) else $error("16-bit roll");

  property p_irq;
    @(posedge clock_i) disable iff (!rstn_i)
    ##1 irq_o == $past(any_pend);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");

  property p_sum;
    @(posedge clock_i) disable iff (!rstn_i)
    wr_flag && pflag_q != 16'h0000 |=> f0_view[BIT_PCHG];
  endproperty
  a_sum: assert property (p_sum) else $error("summary flag");

  property p_gate;
    @(posedge clock_i) disable iff (!rstn_i)
    gate_event_i[2] |=> gflag_q[2];
  endproperty
  a_gate: assert property (p_gate) else $error("gate flag lost");

  property p_novec;
    @(posedge clock_i) disable iff (!rstn_i)
    !global_enable_bit |=> !vec_req_o;
  endproperty
  a_novec: assert property (p_novec) else $error("vector w/o gie");

  property p_step;
    @(posedge clock_i) disable iff (!rstn_i)
    st_q == ST_STEP && !step_done_i |=> !vec_req_o && st_q == ST_STEP;
  endproperty
  a_step: assert property (p_step) else $error("vector before step");

  property p_ctx;
    @(posedge clock_i) disable iff (!rstn_i)
    vec_ack_i |=> ret_pc_o == $past(pc_i) && shadow_bsr_o == $past(bsr_i);
  endproperty
  a_ctx: assert property (p_ctx) else $error("context not saved");

  c_wake: cover property (@(posedge clock_i) disable iff (!rstn_i)
    st_q == ST_SLEEP ##1 st_q == ST_STEP);
  c_vec_hi: cover property (@(posedge clock_i) disable iff (!rstn_i)
    vec_hi_o);
  c_pchg: cover property (@(posedge clock_i) disable iff (!rstn_i)
    pchg_sum && en_q[BIT_PCHG]);
endmodule : interrupt_flag_and_wake_logic
`default_nettype wire

// ### rtl/irq_wake_pkg.sv
// constants for the interrupt flag and wake logic
// assumes an 8-bit register port and 16 change-capable pins
package irq_wake_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIN_N = 16;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned PC_W = 21;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_CTRL0 = 5'h00;
  localparam logic [4:0] OFS_FLAG0 = 5'h01;
  localparam logic [4:0] OFS_EN0 = 5'h02;
  localparam logic [4:0] OFS_PRIO0 = 5'h03;
  localparam logic [4:0] OFS_GFLAG = 5'h04;
  localparam logic [4:0] OFS_GEN = 5'h05;
  localparam logic [4:0] OFS_RISE_L = 5'h06;
  localparam logic [4:0] OFS_RISE_H = 5'h07;
  localparam logic [4:0] OFS_FALL_L = 5'h08;
  localparam logic [4:0] OFS_FALL_H = 5'h09;
  localparam logic [4:0] OFS_PFLAG_L = 5'h0A;
  localparam logic [4:0] OFS_PFLAG_H = 5'h0B;
  localparam logic [4:0] OFS_SEL_A = 5'h0C;
  localparam logic [4:0] OFS_SEL_B = 5'h0D;
  localparam logic [4:0] OFS_SEL_C = 5'h0E;
  localparam logic [4:0] OFS_TCTRL = 5'h0F;
  localparam logic [4:0] OFS_TCNT_L = 5'h10;
  localparam logic [4:0] OFS_TCNT_H = 5'h11;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned BIT_GIE = 7;
  localparam int unsigned BIT_PCHG = 4;
  localparam int unsigned BIT_FIRST_TIMER_COUNT = 5;
  localparam int unsigned BIT_T16 = 0;
  localparam int unsigned BIT_TON = 7;
  // ----------------------------------------
  // reset values and counts
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_SEL = 4'h0;
  localparam logic [7:0] CNT8_TOP = 8'hFF;
  localparam logic [15:0] CNT16_TOP = 16'hFFFF;
  localparam logic [15:0] RST_CNT = 16'h0000;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_STEP = 3'b100
  } wake_state_t;
endpackage : irq_wake_pkg

// ### rtl/pin_edge_if.sv
// bundle of synchronised pin edge pulses, rise and fall
// assumes one clock; pulses last one cycle
`timescale 1ns/1ns
`default_nettype none
interface pin_edge_if;
  logic [15:0] rise;
  logic [15:0] fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : pin_edge_if
`default_nettype wire

// ### rtl/pin_edge_detect.sv
// two-flop synchroniser and edge finder for the pin bank
// assumes pins are asynchronous to clock_i
`timescale 1ns/1ns
`default_nettype none
module pin_edge_detect (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [15:0] pins_i,
  pin_edge_if.src edges
);
  logic [15:0] meta_q;
  logic [15:0] sync_q;
  logic [15:0] last_q;
  // ----------------------------------------
  // synchroniser; meta_q feeds sync_q only
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= 16'h0000;
      sync_q <= 16'h0000;
      last_q <= 16'h0000;
    end else begin
      meta_q <= pins_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign edges.rise = sync_q & ~last_q;
  assign edges.fall = ~sync_q & last_q;
endmodule : pin_edge_detect
`default_nettype wire

// ### sim/core_model.sv
// core-side model: sleeps on command, runs one step, takes the vector
// assumes the block's wake and vector handshake share clock_i
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic sleep_cmd_i,
  input wire logic [3:0] lat_i,
  input wire logic wake_i,
  input wire logic vec_req_i,
  output logic sleep_o,
  output logic step_o,
  output logic ack_o,
  output int n_wake_o,
  output int n_ack_o,
  output logic early_o
);
  // -----------------------------
  // handshake
  // -----------------------------
  logic [3:0] cnt_q;
  logic take;
  // lat_i of 1..8 gives a prompt or a slow core
  assign take = vec_req_i && !ack_o && !sleep_o && (cnt_q == 4'h0);
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sleep_o <= 1'b0;
      step_o <= 1'b0;
      ack_o <= 1'b0;
      cnt_q <= 4'h0;
      n_wake_o <= 0;
      n_ack_o <= 0;
      early_o <= 1'b0;
    end else begin
      step_o <= (cnt_q == 4'h1);
      cnt_q <= (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
      ack_o <= take;
      if (take) n_ack_o <= n_ack_o + 1;
      if (vec_req_i && (sleep_o || cnt_q != 4'h0)) early_o <= 1'b1;
      if (sleep_cmd_i) sleep_o <= 1'b1;
      if (sleep_o && wake_i) begin
        sleep_o <= 1'b0;
        cnt_q <= lat_i;
        n_wake_o <= n_wake_o + 1;
      end
    end
  end
endmodule : core_model
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the interrupt flag and wake logic
// assumes core_model answers the wake and vector handshake
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import irq_wake_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic [4:0] addr = '0;
  logic [7:0] wdata = '0;
  logic wr = 0;
  logic rd = 0;
  logic [15:0] pins = '0;
  logic tick = 0;
  logic [2:0] gev = '0;
  logic sleep_cmd = 0;
  logic [3:0] lat = 4'h1;
  logic [20:0] pc = '0;
  logic [7:0] working_register = '0;
  logic [7:0] stat = '0;
  logic [7:0] bank_select_register = '0;
  logic [7:0] rdata, sh_w, sh_s, sh_b;
  logic [20:0] ret_pc;
  logic core_sleep, step_done, vec_ack, irq, wake, vreq, vhi, early;
  int n_wake, n_ack, i, k, p;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h0001_2DF9;
  always #5 clk = ~clk;
  interrupt_flag_and_wake_logic i_interrupt_flag_and_wake_logic (
    .clock_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pins_i(pins),
    .timer_tick_i(tick), .gate_event_i(gev), .core_sleep_i(core_sleep),
    .step_done_i(step_done), .vec_ack_i(vec_ack), .pc_i(pc),
    .working_register_i(working_register), .status_i(stat), .bsr_i(bank_select_register), .irq_o(irq),
    .wake_o(wake), .vec_req_o(vreq), .vec_hi_o(vhi), .ret_pc_o(ret_pc),
    .shadow_working_register_o(sh_w), .shadow_status_o(sh_s), .shadow_bsr_o(sh_b));
  core_model i_core_model (
    .clock_i(clk), .rstn_i(rstn), .sleep_cmd_i(sleep_cmd), .lat_i(lat),
    .wake_i(wake), .vec_req_i(vreq), .sleep_o(core_sleep),
    .step_o(step_done), .ack_o(vec_ack), .n_wake_o(n_wake),
    .n_ack_o(n_ack), .early_o(early));
  // -----------------------------
  // helpers
  // -----------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [7:0] bitv(input int n);
    return 8'h01 << n;
  endfunction : bitv
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask : waitc
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rchk(input string nm, input logic [4:0] a,
                      input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata & m);
  endtask : rchk
  task automatic ticks(input int n);
    repeat (n) @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
    waitc(2);
  endtask : ticks
  // ext a on pin 0; pre says whether its enable stood before sleep
  task automatic wake_run(input logic g, input logic pr, input logic pre);
    logic [31:0] r;
    int w0;
    int seen;
    int a0;
    w0 = n_wake;
    seen = 0;
    r = xs();
    pins <= '0;
    pc <= r[20:0];
    working_register <= r[28:21];
    lat <= 4'(r[31:29]) + 4'h1;
    r = xs();
    stat <= r[7:0];
    bank_select_register <= r[15:8];
    wr_reg(OFS_SEL_A, 8'h00);
    wr_reg(OFS_CTRL0, {g, 7'h01});
    wr_reg(OFS_PRIO0, {7'h00, pr});
    wr_reg(OFS_FLAG0, 8'h37);
    wr_reg(OFS_GFLAG, 8'h07);
    wr_reg(OFS_GEN, 8'h01);
    wr_reg(OFS_EN0, {7'h00, pre});
    @(posedge clk) sleep_cmd <= 1'b1;
    @(posedge clk) sleep_cmd <= 1'b0;
    waitc(3);
    a0 = n_ack;
    if (!pre) wr_reg(OFS_EN0, 8'h01);
    pins[0] <= 1'b1;
    if (!pre) begin
      waitc(30);
      chk("no_wake", w0, n_wake);
      @(posedge clk) gev <= 3'h1;
      @(posedge clk) gev <= 3'h0;
    end
    for (i = 0; i < 100 && seen == 0; i++) begin
      @(posedge clk);
      #1;
      if (vreq === 1'b1) begin
        seen = 1;
        chk("prio", pr, vhi);
      end
    end
    chk("vectored", g, seen);
    chk("woke", w0 + 1, n_wake);
    chk("early", 0, early);
    waitc(3);
    chk("acked", g, n_ack > a0);
    if (g) begin
      chk("ret_pc", pc, ret_pc);
      chk("sh_w", working_register, sh_w);
      chk("sh_s", stat, sh_s);
      chk("sh_b", bank_select_register, sh_b);
    end
  endtask : wake_run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    // about 70k cycles of tests; a hang stops short of 100k
    #950_000;
    n_mismatch++;
    end_of_test();
  end
  // -----------------------------
  // scenarios
  // -----------------------------
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    waitc(3);
    for (k = 0; k < 18; k++) rchk("rst", 5'(k), 8'hFF, RST_BYTE);
    rchk("unmapped", 5'h1F, 8'hFF, 8'h00);
    for (k = 0; k < 3; k++) begin
      @(posedge clk) gev <= 3'(bitv(k));
      @(posedge clk) gev <= 3'h0;
      waitc(2);
      rchk("gflag", OFS_GFLAG, 8'hFF, bitv(k));
      chk("irq_masked", 0, irq);
      wr_reg(OFS_GEN, bitv(k));
      waitc(2);
      chk("irq_on", 1, irq);
      wr_reg(OFS_GFLAG, bitv(k));
      waitc(2);
      rchk("gclr", OFS_GFLAG, 8'hFF, 8'h00);
      chk("irq_off", 0, irq);
      wr_reg(OFS_GEN, 8'h00);
    end
    // edge bit 0 then 1 for each request, random pin
    for (k = 0; k < 6; k++) begin
      p = int'(xs() % 16);
      wr_reg(OFS_SEL_A + 5'(k / 2), 8'(p));
      wr_reg(OFS_CTRL0, 8'(k % 2) << (k / 2));
      pins <= {16{k[0]}};
      waitc(6);
      wr_reg(OFS_FLAG0, 8'h07);
      pins[p] <= ~k[0];
      waitc(8);
      rchk("ext_off", OFS_FLAG0, bitv(k / 2), 8'h00);
      pins[p] <= k[0];
      waitc(8);
      rchk("ext_hit", OFS_FLAG0, bitv(k / 2), bitv(k / 2));
    end
    p = int'(xs() % 16);
    pins <= '0;
    waitc(6);
    wr_reg(OFS_FLAG0, 8'h07);
    wr_reg(OFS_RISE_L + 5'(p / 8), bitv(p % 8));
    pins[(p + 1) % 16] <= 1'b1;
    waitc(8);
    rchk("ioc_unsel", OFS_FLAG0, 8'h10, 8'h00);
    pins[p] <= 1'b1;
    waitc(8);
    rchk("ioc_sum", OFS_FLAG0, 8'h10, 8'h10);
    rchk("ioc_pin", OFS_PFLAG_L + 5'(p / 8), 8'hFF, bitv(p % 8));
    chk("ioc_irq0", 0, irq);
    wr_reg(OFS_EN0, 8'h10);
    waitc(2);
    chk("ioc_irq1", 1, irq);
    wr_reg(OFS_FLAG0, 8'h10);
    waitc(2);
    rchk("ioc_ro", OFS_FLAG0, 8'h10, 8'h10);
    wr_reg(OFS_PFLAG_L + 5'(p / 8), bitv(p % 8));
    waitc(2);
    rchk("ioc_clr", OFS_FLAG0, 8'h10, 8'h00);
    wr_reg(OFS_EN0, 8'h00);
    wr_reg(OFS_RISE_L + 5'(p / 8), 8'h00);
    wr_reg(OFS_TCTRL, 8'h80);
    ticks(255);
    rchk("t8_cnt", OFS_TCNT_L, 8'hFF, CNT8_TOP);
    rchk("t8_pre", OFS_FLAG0, 8'h20, 8'h00);
    ticks(1);
    rchk("t8_roll", OFS_FLAG0, 8'h20, 8'h20);
    rchk("t8_hi", OFS_TCNT_H, 8'hFF, 8'h00);
    wr_reg(OFS_FLAG0, 8'h20);
    wr_reg(OFS_TCTRL, 8'h81);
    ticks(65535);
    rchk("t16_hi", OFS_TCNT_H, 8'hFF, CNT16_TOP[15:8]);
    rchk("t16_pre", OFS_FLAG0, 8'h20, 8'h00);
    ticks(1);
    rchk("t16_roll", OFS_FLAG0, 8'h20, 8'h20);
    chk("t_irq0", 0, irq);
    wr_reg(OFS_EN0, 8'h20);
    waitc(2);
    chk("t_irq1", 1, irq);
    wr_reg(OFS_TCTRL, 8'h00);
    p = int'(xs() % 2);
    wake_run(1'b1, p[0], 1'b1);
    wake_run(1'b1, ~p[0], 1'b1);
    wake_run(1'b0, 1'b0, 1'b1);
    wake_run(1'b0, 1'b0, 1'b0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
